// ===== logic/bbem_bitband_monitor.sv
// Bit-band remapper and exclusive monitor between core load/store and memory.
// Assumes core requests and memory answers are on CLK_I; memory acks a held
// request after any number of cycles; the core always takes RSP_VALID_O.
`timescale 1ns/100ps
module bbem_bitband_monitor
  import bbem_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Core request
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic REQ_WRITE_I,
  input wire logic REQ_FETCH_I,
  input wire logic REQ_EXCL_I,
  input wire logic [1:0] REQ_SIZE_I,
  input wire logic [31:0] REQ_ADDR_I,
  input wire logic [31:0] REQ_WDATA_I,
  // Core response
  output logic RSP_VALID_O,
  output logic [31:0] RSP_RDATA_O,
  output logic RSP_EXFAIL_O,
  // Core events
  input wire logic CLEAR_EXCL_I,
  input wire logic EXCEPTION_I,
  // Memory port
  output logic MEM_REQ_O,
  output logic MEM_WRITE_O,
  output logic [31:0] MEM_ADDR_O,
  output logic [1:0] MEM_SIZE_O,
  output logic [3:0] MEM_BE_O,
  output logic [31:0] MEM_WDATA_O,
  input wire logic MEM_ACK_I,
  input wire logic [31:0] MEM_RDATA_I
);

  bbem_state_e state;
  logic take;
  logic sram_hit;
  logic peri_hit;
  logic alias_hit;
  logic [31:0] alias_off;
  logic [31:0] target;
  logic excl_st_fail;
  logic cur_write;
  logic cur_alias;
  logic cur_excl;
  logic cur_bit;
  logic [4:0] bitpos;
  logic [31:0] mem_addr;
  logic [1:0] mem_size;
  logic [31:0] wdata;
  logic [31:0] rsp_data;
  logic rsp_fail;

  bbem_excl_if xif ();

  // ==========================================================================
  // Request decode; fetches never remap
  assign take = REQ_VALID_I && REQ_READY_O;
  assign sram_hit = bbem_in(REQ_ADDR_I, BBEM_SRAM_ALIAS_LO,
                            BBEM_SRAM_ALIAS_HI);
  assign peri_hit = bbem_in(REQ_ADDR_I, BBEM_PERI_ALIAS_LO,
                            BBEM_PERI_ALIAS_HI);
  assign alias_hit = !REQ_FETCH_I && (sram_hit || peri_hit);
  assign alias_off = REQ_ADDR_I - (sram_hit ? BBEM_SRAM_ALIAS_LO
                                            : BBEM_PERI_ALIAS_LO);
  // Target byte = base + offset / 32; bit number = (offset / 4) mod 8
  assign target = alias_hit ?
    (sram_hit ? BBEM_SRAM_BB_BASE : BBEM_PERI_BB_BASE)
      + (alias_off >> BBEM_BYTE_SHIFT) : REQ_ADDR_I;
  assign excl_st_fail = REQ_EXCL_I && REQ_WRITE_I && !xif.held;

  // Tag control; the tag records the address the core used
  assign xif.set = take && REQ_EXCL_I && !REQ_WRITE_I;
  assign xif.clear = CLEAR_EXCL_I || EXCEPTION_I
    || (take && REQ_EXCL_I && REQ_WRITE_I);
  assign xif.addr = REQ_ADDR_I;
  assign xif.size = REQ_SIZE_I;

  bbem_excl_tag u_tag (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .x (xif)
  );

  // ==========================================================================
  // Sequencer: alias writes take a read then a write
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state <= BBEM_IDLE;
    end else begin
      unique case (state)
        BBEM_IDLE: begin
          if (take) begin
            if (excl_st_fail) begin
              state <= BBEM_RESP;
            end else if (REQ_WRITE_I && !alias_hit) begin
              state <= BBEM_WRITE;
            end else begin
              state <= BBEM_READ;
            end
          end
        end
        BBEM_READ: begin
          if (MEM_ACK_I) begin
            state <= (cur_alias && cur_write) ? BBEM_WRITE : BBEM_RESP;
          end
        end
        BBEM_WRITE: begin
          if (MEM_ACK_I) begin
            state <= BBEM_RESP;
          end
        end
        BBEM_RESP: begin
          state <= BBEM_IDLE;
        end
      endcase
    end
  end

  // Latched request attributes
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cur_write <= 1'b0;
      cur_alias <= 1'b0;
      cur_excl <= 1'b0;
      cur_bit <= 1'b0;
      bitpos <= 5'h00;
      mem_addr <= 32'h0000_0000;
      mem_size <= BBEM_SZ_WORD;
    end else if (take) begin
      cur_write <= REQ_WRITE_I;
      cur_alias <= alias_hit;
      cur_excl <= REQ_EXCL_I;
      cur_bit <= REQ_WDATA_I[BBEM_WR_BIT];
      // Lane * 8 + bit number: little-endian bit inside the word
      bitpos <= {target[1:0],
                 alias_off[BBEM_BITNUM_LSB +: BBEM_BITNUM_W]};
      mem_addr <= target;
      mem_size <= REQ_SIZE_I;
    end
  end

  // Write data: core data directly, or the read word with one bit replaced
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wdata <= 32'h0000_0000;
    end else if (take) begin
      wdata <= REQ_WDATA_I;
    end else if (state == BBEM_READ && MEM_ACK_I && cur_alias) begin
      wdata <= MEM_RDATA_I;
      wdata[bitpos] <= cur_bit;
    end
  end

  // Response data and exclusive status
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rsp_data <= 32'h0000_0000;
      rsp_fail <= 1'b0;
    end else if (take) begin
      rsp_data <= 32'h0000_0000;
      rsp_fail <= excl_st_fail;
    end else if (state == BBEM_READ && MEM_ACK_I && !cur_write) begin
      if (cur_alias) begin
        rsp_data <= MEM_RDATA_I[bitpos] ? BBEM_ALIAS_SET
                                        : BBEM_ALIAS_CLR;
      end else begin
        rsp_data <= MEM_RDATA_I;
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign REQ_READY_O = (state == BBEM_IDLE);
  assign RSP_VALID_O = (state == BBEM_RESP);
  assign RSP_RDATA_O = rsp_data;
  assign RSP_EXFAIL_O = rsp_fail;
  assign MEM_REQ_O = (state == BBEM_READ) || (state == BBEM_WRITE);
  assign MEM_WRITE_O = (state == BBEM_WRITE);
  assign MEM_ADDR_O = mem_addr;
  assign MEM_SIZE_O = mem_size;
  assign MEM_BE_O = bbem_be(mem_size, mem_addr[1:0]);
  assign MEM_WDATA_O = wdata;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_alias_rd_ack;
    state == BBEM_READ && MEM_ACK_I && cur_alias;
  endsequence

  sequence s_rmw_write;
    MEM_WRITE_O && MEM_WDATA_O[bitpos] == cur_bit;
  endsequence

  rmw_bit_value_a: assert property (
    s_alias_rd_ack ##0 cur_write |=> s_rmw_write)
    else $error("alias write did not place bit 0 of data");
  rmw_keep_rest_a: assert property (
    s_alias_rd_ack ##0 cur_write
    |=> ((MEM_WDATA_O ^ $past(MEM_RDATA_I)) & ~(32'h1 << bitpos)) == 32'h0)
    else $error("alias write disturbed other bits");
  alias_read_val_a: assert property (
    s_alias_rd_ack ##0 !cur_write
    |=> RSP_VALID_O && RSP_RDATA_O[31:1] == 31'h0
    && RSP_RDATA_O[0] == $past(MEM_RDATA_I[bitpos]))
    else $error("alias read value wrong");
  alias_map_a: assert property (
    take && alias_hit && sram_hit
    |=> MEM_ADDR_O == BBEM_SRAM_BB_BASE + ($past(REQ_ADDR_I)
    - BBEM_SRAM_ALIAS_LO) / 32)
    else $error("alias address mapped wrongly");
  fetch_direct_a: assert property (
    take && REQ_FETCH_I
    |=> MEM_ADDR_O == $past(REQ_ADDR_I) && !cur_alias)
    else $error("fetch was remapped");
  same_size_a: assert property (
    take |=> MEM_SIZE_O == $past(REQ_SIZE_I))
    else $error("memory access size differs");
  // Lane checked directly, not through the enable decoder
  byte_lane_a: assert property (
    MEM_REQ_O && MEM_SIZE_O == BBEM_SZ_BYTE
    |-> MEM_BE_O[MEM_ADDR_O[1:0]] && $onehot(MEM_BE_O))
    else $error("byte lane not little-endian");
  excl_fail_a: assert property (
    take && excl_st_fail
    |=> RSP_VALID_O && RSP_EXFAIL_O && !MEM_REQ_O)
    else $error("failed exclusive store not reported or written");
  excl_st_clear_a: assert property (
    take && REQ_EXCL_I && REQ_WRITE_I |=> !xif.tag)
    else $error("exclusive store left the tag set");
  exc_clear_a: assert property (
    EXCEPTION_I && !xif.set |=> !xif.tag)
    else $error("exception left the tag set");

endmodule : bbem_bitband_monitor

// ===== logic/bbem_excl_if.sv
// Carrier between the access sequencer and the exclusive tag holder.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface bbem_excl_if;
  logic set;
  logic clear;
  logic [31:0] addr;
  logic [1:0] size;
  logic held;
  logic tag;

  modport mon (input set, input clear, input addr, input size,
               output held, output tag);
  modport ctl (output set, output clear, output addr, output size,
               input held, input tag);
endinterface : bbem_excl_if

// ===== logic/bbem_excl_tag.sv
// Exclusive access tag: one address and size, set by exclusive loads.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/100ps
module bbem_excl_tag
  import bbem_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Tag port
  bbem_excl_if.mon x
);

  logic tag;
  logic [31:0] tag_addr;
  logic [1:0] tag_size;

  // ==========================================================================
  // Tag flag; a set in the same cycle as a clear wins so no load is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tag <= 1'b0;
    end else if (x.set) begin
      tag <= 1'b1;
    end else if (x.clear) begin
      tag <= 1'b0;
    end
  end

  // Location and size recorded by the exclusive load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tag_addr <= 32'h0000_0000;
      tag_size <= BBEM_SZ_WORD;
    end else if (x.set) begin
      tag_addr <= x.addr;
      tag_size <= x.size;
    end
  end

  // Held only for the same location at the same size
  assign x.held = tag && (tag_addr == x.addr) && (tag_size == x.size);
  assign x.tag = tag;

  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_load;
    x.set;
  endsequence

  load_sets_tag_a: assert property (
    s_load |=> tag && tag_addr == $past(x.addr))
    else $error("exclusive load did not set the tag");
  clear_exclusive_tag_clears_a: assert property (
    x.clear && !x.set |=> !tag)
    else $error("clear did not drop the tag");
  // Reset must be watched while it is high, so the default disable is lifted
  reset_clear_a: assert property (
    @(posedge clk_i) disable iff (1'b0) rst_i |=> !tag)
    else $error("tag not clear after reset");

endmodule : bbem_excl_tag

// ===== logic/bbem_pkg.sv
// Shared constants, types and helpers for the bit-band and exclusive monitor.
// Assumes a 32-bit byte-addressed memory port with byte enables.
//
// Functional notes
// - Alias write sets the target bit if data bit 0 is one, else clears.
// - Alias data bits 31:1 are ignored: 0xFF acts as 0x01, 0x0E as 0x00.
// - Alias read returns 0x00000001 if the bit is set, else 0x00000000.
// - Memory is ascending bytes, little-endian, byte 0 in the low lane.
// - An exclusive load returns the memory value and sets the tag.
// - Held: exclusive store writes, returns 0; else no write, returns 1.
// - Exclusive pairs work at word, halfword and byte size.
// - The clear-exclusive operation clears the tag; an exclusive load taken in the same cycle sets it instead.
// - Every exclusive store clears the tag, pass or fail.
// - Taking an exception clears the tag; an exclusive load taken in the same cycle sets it instead.
// - Alias offset equals byte offset times 32 plus bit number times 4.
// - An alias data write is a read-modify-write of the target location.
// - Data accesses to 0x22000000..0x23FFFFFF remap; fetches do not.
// - The underlying access has the same size as the alias access.
package bbem_pkg;

  // ==========================================================================
  // Address map
  localparam logic [31:0] BBEM_SRAM_ALIAS_LO = 32'h2200_0000;
  localparam logic [31:0] BBEM_SRAM_ALIAS_HI = 32'h23FF_FFFF;
  localparam logic [31:0] BBEM_SRAM_BB_BASE = 32'h2000_0000;
  localparam logic [31:0] BBEM_PERI_ALIAS_LO = 32'h4200_0000;
  localparam logic [31:0] BBEM_PERI_ALIAS_HI = 32'h43FF_FFFF;
  localparam logic [31:0] BBEM_PERI_BB_BASE = 32'h4000_0000;
  localparam int BBEM_BYTE_SHIFT = 5;   // 32 alias bytes per target byte
  localparam int BBEM_BITNUM_LSB = 2;   // 4 alias bytes per target bit
  localparam int BBEM_BITNUM_W = 3;
  localparam int BBEM_WR_BIT = 0;       // Only this data bit is used

  // ==========================================================================
  // Access sizes and alias read values
  localparam logic [1:0] BBEM_SZ_BYTE = 2'h0;
  localparam logic [1:0] BBEM_SZ_HALF = 2'h1;
  localparam logic [1:0] BBEM_SZ_WORD = 2'h2;
  localparam logic [31:0] BBEM_ALIAS_CLR = 32'h0000_0000;
  localparam logic [31:0] BBEM_ALIAS_SET = 32'h0000_0001;

  typedef enum logic [3:0] {
    BBEM_IDLE  = 4'h1,
    BBEM_READ  = 4'h2,
    BBEM_WRITE = 4'h4,
    BBEM_RESP  = 4'h8
  } bbem_state_e;

  // ==========================================================================
  // Little-endian byte enables for a size at a byte address
  function automatic logic [3:0] bbem_be(input logic [1:0] size,
                                         input logic [1:0] lane);
    logic [3:0] be;
    be = 4'hF;
    if (size == BBEM_SZ_BYTE) begin
      be = 4'(4'h1 << lane);
    end else if (size == BBEM_SZ_HALF) begin
      be = lane[1] ? 4'hC : 4'h3;
    end
    return be;
  endfunction : bbem_be

  // Is an address inside one alias window, lo to hi inclusive
  function automatic logic bbem_in(input logic [31:0] a,
                                   input logic [31:0] lo,
                                   input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : bbem_in

endpackage : bbem_pkg

// ===== sim/bbem_mem_model.sv
// Memory model behind the bit-band monitor's memory port.
// Assumes one request held until ack, all on one clock.
`timescale 1ns/100ps
module bbem_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Memory port
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [31:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  input wire logic [1:0] dly_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  // ==========================================================================
  // Storage
  logic [7:0] mem [logic [31:0]];
  logic [1:0] wcnt;
  logic [31:0] wa;

  // Unwritten bytes read as their address pattern, so zero proves nothing
  function automatic logic [7:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'h5A);
  endfunction : rd

  // Ack after the wait count loaded from dly_i at the previous ack; read data toggles outside the ack cycle
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    wa = {addr_i[31:2], 2'h0};
    if (rst_i) begin
      wcnt <= 2'h0;
      rdata_o <= 32'h0;
    end else if (req_i && !ack_o) begin
      if (wcnt != 2'h0) begin
        wcnt <= wcnt - 2'h1;
      end else begin
        ack_o <= 1'b1;
        wcnt <= dly_i;
        for (int k = 0; k < 4; k++) begin
          if (write_i && be_i[k]) mem[wa + k] = wdata_i[8*k +: 8];
          rdata_o[8*k +: 8] <= rd(wa + k);
        end
      end
    end
  end
endmodule : bbem_mem_model

// ===== sim/bitband_exclusive_monitor_bench.sv
// Self-checking bench for the bit-band remapper and exclusive monitor.
// Assumes the memory model answers with random wait cycles.
`timescale 1ns/100ps
module bitband_exclusive_monitor_bench
  import bbem_pkg::*;
;
  // ==========================================================================
  // Signals
  logic clk = 1'b0;
  logic rst, vld, wr, fetch, excl, clr, exc, ready, rsp_vld, exfail;
  logic mreq, mwr, mack;
  logic [1:0] size, msize, dly, exp_ms;
  logic [3:0] mbe;
  logic [31:0] addr, wdata, rdata, maddr, mwdata, mrdata, exp_ma, v, w;
  logic [7:0] sh;
  logic [32:0] exp_q [$];
  int n_fail = 0;
  int n_checks = 0;
  int seed = 32'h68e1;
  int cycles = 0;
  int mode = 0;

  always #2.5 clk = ~clk;

  bbem_bitband_monitor DUT (.CLK_I(clk), .RST_I(rst), .REQ_VALID_I(vld),
    .REQ_READY_O(ready), .REQ_WRITE_I(wr), .REQ_FETCH_I(fetch),
    .REQ_EXCL_I(excl), .REQ_SIZE_I(size), .REQ_ADDR_I(addr),
    .REQ_WDATA_I(wdata), .RSP_VALID_O(rsp_vld), .RSP_RDATA_O(rdata),
    .RSP_EXFAIL_O(exfail), .CLEAR_EXCL_I(clr), .EXCEPTION_I(exc),
    .MEM_REQ_O(mreq), .MEM_WRITE_O(mwr), .MEM_ADDR_O(maddr),
    .MEM_SIZE_O(msize), .MEM_BE_O(mbe), .MEM_WDATA_O(mwdata),
    .MEM_ACK_I(mack), .MEM_RDATA_I(mrdata));

  bbem_mem_model mem_model (.clk_i(clk), .rst_i(rst), .req_i(mreq),
    .write_i(mwr), .addr_i(maddr), .be_i(mbe), .wdata_i(mwdata),
    .dly_i(dly), .ack_o(mack), .rdata_o(mrdata));

  // ==========================================================================
  // Reporting
  task automatic check(input logic [32:0] seen, input logic [32:0] expv);
    n_checks++;
    if (seen !== expv) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // Hang guard; the whole run needs far fewer cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  // Watcher: responses against the oldest note, memory port against mode
  always @(negedge clk) begin
    if (rsp_vld === 1'b1 && exp_q.size() == 0) check(33'h1, 33'h0);
    if (rsp_vld === 1'b1 && exp_q.size() != 0) begin
      check({exfail, rdata}, exp_q.pop_front());
    end
    if (mreq === 1'b1 && mode == 2) check({32'h0, mreq}, 33'h0);
    if (mreq === 1'b1 && mode == 1) begin
      check({1'b0, maddr}, {1'b0, exp_ma});
      check({31'h0, msize}, {31'h0, exp_ms});
      check({29'h0, mbe}, {29'h0, (exp_ms == BBEM_SZ_BYTE) ? 4'h1
        : (exp_ms == BBEM_SZ_HALF) ? 4'h3 : 4'hF});
    end
  end

  // ==========================================================================
  // Drivers: one request at a time, held until taken
  task automatic req(input logic w_i, input logic f_i, input logic x_i,
                     input logic [1:0] s_i, input logic [31:0] a_i,
                     input logic [31:0] d_i, input logic [32:0] e_i);
    int n;
    exp_q.push_back(e_i);
    @(negedge clk);
    vld = 1'b1;
    wr = w_i;
    fetch = f_i;
    excl = x_i;
    size = s_i;
    addr = a_i;
    wdata = d_i;
    dly = 2'($random(seed));
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    vld = 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    // A response that never came must not let the run pass
    if (exp_q.size() != 0) check(33'(exp_q.size()), 33'h0);
  endtask : req

  // One-cycle clear-exclusive (0) or exception (1) pulse
  task automatic pulse(input int which);
    @(negedge clk);
    clr = (which == 0);
    exc = (which == 1);
    @(negedge clk);
    clr = 1'b0;
    exc = 1'b0;
  endtask : pulse

  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask : tend

  // ==========================================================================
  // Main sequence
  initial begin
    {rst, vld, wr, fetch, excl, clr, exc} = 7'h40;
    size = BBEM_SZ_WORD;
    addr = 32'h0;
    wdata = 32'h0;
    dly = 2'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    req(1, 0, 0, BBEM_SZ_WORD, 32'h2000_0010, 32'h4433_2212, 33'h0);
    req(1, 0, 0, BBEM_SZ_BYTE, 32'h2000_0011, 32'h0000_AA00, 33'h0);
    req(0, 0, 0, BBEM_SZ_WORD, 32'h2000_0010, 0, 33'h0_4433_AA12);
    tend("lanes");
    // Every bit of one byte through the alias, all three sizes
    sh = 8'h12;
    mode = 1;
    exp_ma = 32'h2000_0010;
    for (int b = 0; b < 8; b++) begin
      v = (b == 0) ? 32'hFF : (b == 1) ? 32'h0E : $random(seed);
      exp_ms = 2'(b % 3);
      sh[b] = v[0];
      addr = 32'h2200_0200 + 32'(b * 4);
      req(1, 0, 0, exp_ms, addr, v, 33'h0);
      req(0, 0, 0, exp_ms, addr, 0, {32'h0, sh[b]});
    end
    exp_ma = 32'h4000_0000;
    exp_ms = BBEM_SZ_WORD;
    req(1, 0, 0, BBEM_SZ_WORD, 32'h4200_0000, 32'h1, 33'h0);
    mode = 0;
    req(0, 0, 0, BBEM_SZ_WORD, 32'h2000_0010, 0, {9'h0_44, 16'h33AA, sh});
    req(0, 0, 0, BBEM_SZ_WORD, 32'h4000_0000, 0, 33'h0_5958_5B5B);
    req(0, 1, 0, BBEM_SZ_WORD, 32'h2200_0040, 0, 33'h0_1918_1B1A);
    tend("alias");
    // Exclusive pairs at each size, then a repeated failing store
    mode = 2;
    req(1, 0, 1, BBEM_SZ_WORD, 32'h2000_0020, 32'h1234_5678,
        33'h1_0000_0000);
    mode = 0;
    req(1, 0, 0, BBEM_SZ_WORD, 32'h2000_0020, 32'h0, 33'h0);
    w = 32'h0;
    for (int s = 0; s < 3; s++) begin
      v = $random(seed);
      req(0, 0, 1, 2'(s), 32'h2000_0020, 0, {1'b0, w});
      req(1, 0, 1, 2'(s), 32'h2000_0020, v, 33'h0);
      w = (s == 0) ? {w[31:8], v[7:0]} : (s == 1) ? {w[31:16], v[15:0]} : v;
      mode = 2;
      req(1, 0, 1, 2'(s), 32'h2000_0020, ~v, 33'h1_0000_0000);
      mode = 0;
    end
    req(0, 0, 0, BBEM_SZ_WORD, 32'h2000_0020, 0, {1'b0, w});
    tend("exclusive");
    // Clear-exclusive, then exception, each followed by a retry
    for (int e = 0; e < 2; e++) begin
      req(0, 0, 1, BBEM_SZ_WORD, 32'h2000_0020, 0, {1'b0, w});
      pulse(e);
      mode = 2;
      req(1, 0, 1, BBEM_SZ_WORD, 32'h2000_0020, 32'h0,
          33'h1_0000_0000);
      mode = 0;
      // Failed store: load, update and store again
      req(0, 0, 1, BBEM_SZ_WORD, 32'h2000_0020, 0, {1'b0, w});
      w = w + 32'h1;
      req(1, 0, 1, BBEM_SZ_WORD, 32'h2000_0020, w, 33'h0);
    end
    req(0, 0, 0, BBEM_SZ_WORD, 32'h2000_0020, 0, {1'b0, w});
    tend("clear");
    final_report();
  end
endmodule : bitband_exclusive_monitor_bench
